// ==== logic/pcf_params.svh ====
/*
  Timing counts and fixed values for the PCM codec clock and frame control.
  Assumes a 100 MHz system clock; included by both link ends.
*/
`ifndef PCF_PARAMS_SVH
`define PCF_PARAMS_SVH

`define PCF_CLK_FREQ_KHZ 100000
`define PCF_MCLK_FREQ_KHZ 2048
`define PCF_FRAME_RATE_HZ 8000
`define PCF_FRAME_MCLK_HI 11'd256
`define PCF_FRAME_MCLK_LO 11'd193
`define PCF_FRAME_LOSS_FRAMES 2
`define PCF_PIN_IDLE_MCLKS 11'd16
`define PCF_LONG_FS_BITS 3
`define PCF_WORD_BITS 8

`endif

// ==== logic/pcf_pkg.sv ====
/*
  Types shared by both link ends of the PCM codec clock and frame control.
  Assumes nothing of its surroundings.
*/
package pcf_pkg;
  typedef enum logic {PCF_PWR_DOWN = 1'b0, PCF_PWR_UP = 1'b1} pcf_power_t;
  typedef enum logic {PCF_FRAME_SHORT = 1'b0, PCF_FRAME_LONG = 1'b1} pcf_frame_t;
  typedef enum logic {PCF_RATIO_LO = 1'b0, PCF_RATIO_HI = 1'b1} pcf_ratio_t;
endpackage : pcf_pkg

// ==== logic/pcf_link_if.sv ====
/*
  Serial voice link between the timing source (host) and the codec (dev).
  Assumes both ends run on the same system clock; every wire has one driver.
*/
`timescale 1ns/100ps
interface pcf_link_if;
  logic tx_master_clock;
  logic rx_master_clock_powerdown_pin;
  logic tx_bit_clock;
  logic rx_bit_clock_ratio_select_pin;
  logic tx_frame_sync;
  logic rx_frame_sync;
  logic serial_tx_data_out;
  logic serial_rx_data_in;

  modport dev (
    input tx_master_clock,
    input rx_master_clock_powerdown_pin,
    input tx_bit_clock,
    input rx_bit_clock_ratio_select_pin,
    input tx_frame_sync,
    input rx_frame_sync,
    input serial_rx_data_in,
    output serial_tx_data_out
  );

  modport host (
    output tx_master_clock,
    output rx_master_clock_powerdown_pin,
    output tx_bit_clock,
    output rx_bit_clock_ratio_select_pin,
    output tx_frame_sync,
    output rx_frame_sync,
    output serial_rx_data_in,
    input serial_tx_data_out
  );
endinterface : pcf_link_if

// ==== logic/pcf_shifter.sv ====
/*
  Parallel-load, shift-left serial word register used on both link ends.
  Assumes load and shift are single-cycle strobes; load wins over shift.
*/
`timescale 1ns/100ps
module pcf_shifter #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_word,
  input wire logic i_shift,
  input wire logic i_bit,
  output logic o_msb,
  output logic [W-1:0] o_word
);
  logic [W-1:0] word_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      word_reg <= '0;
    end else if (i_load) begin
      word_reg <= i_word;
    end else if (i_shift) begin
      word_reg <= {word_reg[W-2:0], i_bit};
    end
  end

  assign o_msb = word_reg[W-1];
  assign o_word = word_reg;
endmodule : pcf_shifter

// ==== logic/pcf_host_end.sv ====
/*
  Timing source end: makes master, bit and frame clocks from i_clk,
  sends a word per frame and collects the codec's word.
  Assumes the codec end samples the link on the same i_clk.
*/
`timescale 1ns/100ps
`include "pcf_params.svh"
module pcf_host_end #(
  parameter int W = `PCF_WORD_BITS,
  parameter int MCLK_HALF = `PCF_CLK_FREQ_KHZ / (2 * `PCF_MCLK_FREQ_KHZ),
  parameter int FRAME_BITS = (`PCF_MCLK_FREQ_KHZ * 1000) / `PCF_FRAME_RATE_HZ
) (
  input wire logic i_clk,
  input wire logic i_rst,
  pcf_link_if.host link,
  input wire logic i_run,
  input wire logic i_power_down,
  input wire logic i_rx_mclk_run,
  input wire logic i_strap_mode,
  input wire logic i_strap_level,
  input wire pcf_pkg::pcf_frame_t i_frame_mode,
  input wire logic i_no_tx_fs,
  input wire logic i_stop_frames,
  input wire logic i_loopback,
  input wire logic [W-1:0] i_tx_word,
  output logic [W-1:0] o_rx_word,
  output logic o_rx_valid
);
  import pcf_pkg::*;

  logic [7:0] div_reg;
  logic clk_reg;
  logic [10:0] bit_reg;
  logic fs_reg;
  logic fsx_reg;
  logic pdn_reg;
  logic strap_reg;
  logic data_reg;
  logic rx_valid_reg;
  logic tx_msb;

  wire toggle = i_run && (div_reg == 8'(MCLK_HALF - 1));
  wire rise = toggle && !clk_reg;
  wire fall = toggle && clk_reg;
  wire [10:0] bit_next = (bit_reg == 11'(FRAME_BITS - 1)) ? 11'h000 : bit_reg + 11'h001;
  wire fs_next = (i_frame_mode == PCF_FRAME_LONG) ? (bit_next < 11'(`PCF_LONG_FS_BITS))
                                                  : (bit_next == 11'(FRAME_BITS - 1));
  wire tx_load = rise && (bit_next == 11'h000);
  wire tx_shift = rise && (bit_next != 11'h000) && (bit_next < 11'(W));
  wire rx_shift = fall && (bit_reg < 11'(W));
  wire rx_last = fall && (bit_reg == 11'(W - 1));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= 8'h00;
      clk_reg <= 1'b0;
    end else if (i_run) begin
      div_reg <= toggle ? 8'h00 : div_reg + 8'h01;
      clk_reg <= clk_reg ^ toggle;
    end
  end

  // Frame rate counter
  // Frame counter and syncs advance on the bit clock rising edge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_reg <= 11'(FRAME_BITS - 2);
      fs_reg <= 1'b0;
      fsx_reg <= 1'b0;
    end else if (rise) begin
      bit_reg <= bit_next;
      fs_reg <= fs_next && !i_stop_frames;
      fsx_reg <= fs_next && !i_stop_frames && !i_no_tx_fs;
    end
  end

  // Pins never float
  // Pins are always driven, either clocked or held at a fixed level
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pdn_reg <= 1'b1;
      strap_reg <= 1'b0;
      data_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      pdn_reg <= i_power_down || (i_rx_mclk_run && clk_reg);
      strap_reg <= i_strap_mode ? i_strap_level : clk_reg;
      data_reg <= i_loopback ? link.serial_tx_data_out : tx_msb;
      rx_valid_reg <= rx_last;
    end
  end

  pcf_shifter #(.W(W)) u_tx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(tx_load),
    .i_word(i_tx_word),
    .i_shift(tx_shift),
    .i_bit(1'b0),
    .o_msb(tx_msb),
    .o_word()
  );

  pcf_shifter #(.W(W)) u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(1'b0),
    .i_word('0),
    .i_shift(rx_shift),
    .i_bit(link.serial_tx_data_out),
    .o_msb(),
    .o_word(o_rx_word)
  );

  // One shared source
  // Master and bit clocks share one source so they stay synchronous
  assign link.tx_master_clock = clk_reg;
  assign link.tx_bit_clock = clk_reg;
  assign link.rx_master_clock_powerdown_pin = pdn_reg;
  assign link.rx_bit_clock_ratio_select_pin = strap_reg;
  assign link.tx_frame_sync = fsx_reg;
  assign link.rx_frame_sync = fs_reg;
  assign link.serial_rx_data_in = data_reg;
  assign o_rx_valid = rx_valid_reg;
endmodule : pcf_host_end

// ==== logic/pcf_dev_end.sv ====
/*
  Codec end: power-up/down control, clock ratio strap, frame timing mode
  detection and the serial word transfer in both directions.
  Assumes all link pins are synchronous to i_clk and all but serial_tx_data_out are driven by the host end.
*/
`timescale 1ns/100ps
`include "pcf_params.svh"
module pcf_dev_end #(
  parameter int W = `PCF_WORD_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  pcf_link_if.dev link,
  input wire logic [W-1:0] i_tx_word,
  output pcf_pkg::pcf_power_t o_power,
  output pcf_pkg::pcf_frame_t o_frame_mode,
  output pcf_pkg::pcf_ratio_t o_ratio,
  output logic o_tx_taken,
  output logic [W-1:0] o_rx_word,
  output logic o_rx_valid
);
  import pcf_pkg::*;

  localparam int NW = 3;
  localparam int WD_PIN = 0;
  localparam int WD_RXB = 1;
  localparam int WD_FS = 2;

  pcf_power_t power_reg;
  pcf_frame_t mode_reg;
  pcf_ratio_t ratio_reg;
  logic mclk_q;
  logic pdn_q;
  logic bx_q;
  logic br_q;
  logic rb_q;
  logic fsx_q;
  logic [1:0] xrun_reg;
  logic [1:0] rrun_reg;
  logic [3:0] txcnt_reg;
  logic [3:0] rxcnt_reg;
  logic taken_reg;
  logic rx_valid_reg;
  logic tx_msb;
  wire [NW-1:0] wd_kick;
  wire [NW-1:0] wd_idle;
  wire [10:0] wd_limit [NW];

  // Edges of the sampled link pins
  wire mclk_rise = link.tx_master_clock && !mclk_q;
  wire bx_rise = link.tx_bit_clock && !bx_q;
  wire fsx_rise = link.tx_frame_sync && !fsx_q;
  wire pdn_edge = link.rx_master_clock_powerdown_pin ^ pdn_q;
  wire br_edge = link.rx_bit_clock_ratio_select_pin ^ br_q;
  wire powered = (power_reg == PCF_PWR_UP);
  wire is_long = (mode_reg == PCF_FRAME_LONG);

  // Receive side uses its own bit clock pin only while it toggles
  wire rxb_active = !wd_idle[WD_RXB];
  wire rb = rxb_active ? link.rx_bit_clock_ratio_select_pin : link.tx_bit_clock;
  wire rb_rise = rb && !rb_q;
  wire rb_fall = !rb && rb_q;

  // Frame loss window scales with the selected master clock ratio
  wire [10:0] frame_mclks = (ratio_reg == PCF_RATIO_HI) ? `PCF_FRAME_MCLK_HI
                                                        : `PCF_FRAME_MCLK_LO;
  assign wd_limit[WD_PIN] = `PCF_PIN_IDLE_MCLKS;
  assign wd_limit[WD_RXB] = `PCF_PIN_IDLE_MCLKS;
  assign wd_limit[WD_FS] = 11'(frame_mclks * `PCF_FRAME_LOSS_FRAMES);
  assign wd_kick[WD_PIN] = pdn_edge;
  assign wd_kick[WD_RXB] = br_edge;
  assign wd_kick[WD_FS] = fsx_rise;

  genvar g;
  generate
    for (g = 0; g < NW; g++) begin : g_wd
      logic [10:0] cnt_reg;
      assign wd_idle[g] = (cnt_reg >= wd_limit[g]);
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          cnt_reg <= 11'h7ff;
        end else if (wd_kick[g]) begin
          cnt_reg <= 11'h000;
        end else if (mclk_rise && !wd_idle[g]) begin
          cnt_reg <= cnt_reg + 11'h001;
        end
      end
    end
  endgenerate

  wire pin_down = wd_idle[WD_PIN] && link.rx_master_clock_powerdown_pin;
  wire frame_lost = wd_idle[WD_FS];
  wire pcf_power_t power_next = (pin_down || frame_lost) ? PCF_PWR_DOWN : PCF_PWR_UP;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mclk_q <= 1'b0;
      pdn_q <= 1'b1;
      bx_q <= 1'b0;
      br_q <= 1'b0;
      rb_q <= 1'b0;
      fsx_q <= 1'b0;
    end else begin
      mclk_q <= link.tx_master_clock;
      pdn_q <= link.rx_master_clock_powerdown_pin;
      bx_q <= link.tx_bit_clock;
      br_q <= link.rx_bit_clock_ratio_select_pin;
      rb_q <= rb;
      fsx_q <= link.tx_frame_sync;
    end
  end

  // State changes only on master clock
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      power_reg <= PCF_PWR_DOWN;
    end else if (mclk_rise) begin
      power_reg <= power_next;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ratio_reg <= PCF_RATIO_HI;
    end else if (mclk_rise && !rxb_active) begin
      ratio_reg <= link.rx_bit_clock_ratio_select_pin ? PCF_RATIO_HI : PCF_RATIO_LO;
    end
  end

  // Sync run lengths, in bit clock periods, saturating at three
  wire [1:0] xrun_next = !link.tx_frame_sync ? 2'h0 :
                         (xrun_reg == 2'h3) ? 2'h3 : xrun_reg + 2'h1;
  wire [1:0] rrun_next = !link.rx_frame_sync ? 2'h0 :
                         (rrun_reg == 2'h3) ? 2'h3 : rrun_reg + 2'h1;
  wire long_seen = bx_rise && link.tx_frame_sync && (xrun_reg != 2'h0);
  wire short_seen = bx_rise && !link.tx_frame_sync && (xrun_reg == 2'h1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      xrun_reg <= 2'h0;
      rrun_reg <= 2'h0;
    end else begin
      if (bx_rise) begin
        xrun_reg <= xrun_next;
      end
      if (rb_rise) begin
        rrun_reg <= rrun_next;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= PCF_FRAME_SHORT;
    end else if (!powered) begin
      mode_reg <= PCF_FRAME_SHORT;
    end else if (long_seen) begin
      mode_reg <= PCF_FRAME_LONG;
    end else if (short_seen) begin
      mode_reg <= PCF_FRAME_SHORT;
    end
  end

  // Long frames start with the sync edge, short ones after the sync bit
  wire tx_start = powered && bx_rise && (is_long ? (link.tx_frame_sync && xrun_reg == 2'h0)
                                                 : short_seen);
  wire rx_start = powered && rb_rise &&
                  (is_long ? (link.rx_frame_sync && rrun_reg == 2'h0)
                           : (!link.rx_frame_sync && rrun_reg == 2'h1));
  wire tx_shift = bx_rise && (txcnt_reg != 4'h0) && !tx_start;
  wire rx_shift = rb_fall && (rxcnt_reg != 4'h0);
  wire rx_last = rx_shift && (rxcnt_reg == 4'(W));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      txcnt_reg <= 4'h0;
      rxcnt_reg <= 4'h0;
      taken_reg <= 1'b0;
      rx_valid_reg <= 1'b0;
    end else begin
      taken_reg <= tx_start;
      rx_valid_reg <= rx_last;
      if (tx_start) begin
        txcnt_reg <= 4'h1;
      end else if (tx_shift) begin
        txcnt_reg <= (txcnt_reg == 4'(W)) ? 4'h0 : txcnt_reg + 4'h1;
      end
      if (rx_start) begin
        rxcnt_reg <= 4'h1;
      end else if (rx_shift) begin
        rxcnt_reg <= rx_last ? 4'h0 : rxcnt_reg + 4'h1;
      end
    end
  end

  pcf_shifter #(.W(W)) u_tx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(tx_start),
    .i_word(i_tx_word),
    .i_shift(tx_shift),
    .i_bit(1'b0),
    .o_msb(tx_msb),
    .o_word()
  );

  pcf_shifter #(.W(W)) u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(1'b0),
    .i_word('0),
    .i_shift(rx_shift),
    .i_bit(link.serial_rx_data_in),
    .o_msb(),
    .o_word(o_rx_word)
  );

  // Power-down stops new word loads; a word already started still shifts out whole, then zeros follow on the line
  assign link.serial_tx_data_out = tx_msb;
  assign o_power = power_reg;
  assign o_frame_mode = mode_reg;
  assign o_ratio = ratio_reg;
  assign o_tx_taken = taken_reg;
  assign o_rx_valid = rx_valid_reg;
endmodule : pcf_dev_end

// ==== tb/pcf_chk.sv ====
/*
  Checker for the codec end's power, ratio and frame timing mode.
  Assumes one clock; sees the link wires and the codec end's status.
*/
`timescale 1ns/100ps
module pcf_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic tx_master_clock,
  input wire logic rx_master_clock_powerdown_pin,
  input wire logic rx_bit_clock_ratio_select_pin,
  input wire logic tx_frame_sync,
  input wire logic rx_frame_sync,
  input wire pcf_pkg::pcf_power_t o_power,
  input wire pcf_pkg::pcf_frame_t o_frame_mode,
  input wire pcf_pkg::pcf_ratio_t o_ratio,
  input wire logic o_tx_taken
);
  import pcf_pkg::*;
  logic [4:0] prv_reg;
  logic [15:0] pdn_reg, sel_reg, loss_reg, idle_reg, low_reg, hi_reg;
  wire mck_rise = tx_master_clock & ~prv_reg[4];
  wire pdn_edge = rx_master_clock_powerdown_pin ^ prv_reg[3];
  wire sel_edge = rx_bit_clock_ratio_select_pin ^ prv_reg[2];
  wire fs_rise = (tx_frame_sync & ~prv_reg[1]) | (rx_frame_sync & ~prv_reg[0]);
  wire [15:0] inc = {15'h0, mck_rise};
  // Pin, strap and sync-loss counts are in master clock rises, with a margin of two (pins) or eight (frame loss) over the codec's own
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prv_reg <= 5'h00;
      {pdn_reg, sel_reg, loss_reg, idle_reg, low_reg, hi_reg} <= 96'h0;
    end else begin
      prv_reg <= {tx_master_clock, rx_master_clock_powerdown_pin,
        rx_bit_clock_ratio_select_pin, tx_frame_sync, rx_frame_sync};
      pdn_reg <= pdn_edge ? 16'h0 : pdn_reg + inc;
      sel_reg <= sel_edge ? 16'h0 : sel_reg + inc;
      loss_reg <= fs_rise ? 16'h0 : loss_reg + inc;
      idle_reg <= (tx_master_clock ^ prv_reg[4]) ? 16'h0 : idle_reg + 16'h1;
      low_reg <= tx_frame_sync ? 16'h0 : low_reg + 16'h1;
      hi_reg <= tx_frame_sync ? hi_reg + inc : 16'h0;
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  sequence s_long_fs;
    o_power == PCF_PWR_UP && mck_rise && tx_frame_sync && hi_reg == 16'h1;
  endsequence
  sequence s_short_fs;
    o_power == PCF_PWR_UP && mck_rise && !tx_frame_sync && hi_reg == 16'h1;
  endsequence
  property p_pin_down;
    prv_reg[3] && pdn_reg >= 16'h12 |-> o_power == PCF_PWR_DOWN;
  endproperty
  property p_loss_down;
    loss_reg >= 16'h208 |-> o_power == PCF_PWR_DOWN;
  endproperty
  property p_frozen;
    idle_reg >= 16'h6 |-> $stable(o_power);
  endproperty
  property p_ratio;
    sel_reg >= 16'h12 |-> o_ratio == pcf_ratio_t'(prv_reg[2]);
  endproperty
  property p_down_short;
    o_power == PCF_PWR_DOWN [*3] |-> o_frame_mode == PCF_FRAME_SHORT;
  endproperty
  property p_long_set;
    s_long_fs |-> ##[1:4] o_frame_mode == PCF_FRAME_LONG;
  endproperty
  property p_short_set;
    s_short_fs |-> ##[1:4] o_frame_mode == PCF_FRAME_SHORT;
  endproperty
  property p_no_tx_long;
    low_reg >= 16'h8 |->
      !(o_frame_mode == PCF_FRAME_LONG && $past(o_frame_mode) == PCF_FRAME_SHORT);
  endproperty
  property p_down_idle;
    o_power == PCF_PWR_DOWN [*4] |-> !o_tx_taken;
  endproperty
  a_pin_down: assert property (p_pin_down)
    else $error("still up with power pin high");
  a_loss_down: assert property (p_loss_down)
    else $error("still up without frame syncs");
  a_frozen: assert property (p_frozen)
    else $error("power changed without master clock");
  a_ratio: assert property (p_ratio)
    else $error("ratio differs from strap");
  a_down_short: assert property (p_down_short)
    else $error("long mode while powered down");
  a_long_set: assert property (p_long_set)
    else $error("long sync not followed");
  a_short_set: assert property (p_short_set)
    else $error("short sync not followed");
  a_no_tx_long: assert property (p_no_tx_long)
    else $error("long mode without transmit sync");
  a_down_idle: assert property (p_down_idle)
    else $error("word taken while powered down");
endmodule : pcf_chk

// ==== tb/pcm_codec_clock_frame_control_tb_top.sv ====
/*
  Self-checking bench: timing source end and codec end joined by the link.
  Assumes the shared parameter header is on the include path.
*/
`timescale 1ns/100ps
module pcm_codec_clock_frame_control_tb_top;
  import pcf_pkg::*;
  // Short frames keep the run small; frame loss still needs 512 master clocks
  localparam int MC = 12;
  localparam int FR = 32 * MC;
  localparam int LIMIT = 90000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run, pdn, mrun, smode, slevel, notx, stop, loop, hval, dtaken, dval;
  logic [7:0] htx, dtx, hrx, drx;
  logic [31:0] seed = 32'h9e1d2956;
  pcf_frame_t fmode, dmode;
  pcf_power_t dpow;
  pcf_ratio_t drat;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int t0 = 0;
  pcf_link_if pcf_link_if_i ();
  pcf_host_end #(.MCLK_HALF(6), .FRAME_BITS(32)) pcf_host_end_i (.i_clk(clk), .i_rst(rst),
    .link(pcf_link_if_i.host), .i_run(run), .i_power_down(pdn), .i_rx_mclk_run(mrun),
    .i_strap_mode(smode), .i_strap_level(slevel), .i_frame_mode(fmode), .i_no_tx_fs(notx),
    .i_stop_frames(stop), .i_loopback(loop), .i_tx_word(htx), .o_rx_word(hrx),
    .o_rx_valid(hval));
  pcf_dev_end pcf_dev_end_i (.i_clk(clk), .i_rst(rst), .link(pcf_link_if_i.dev),
    .i_tx_word(dtx), .o_power(dpow), .o_frame_mode(dmode), .o_ratio(drat),
    .o_tx_taken(dtaken), .o_rx_word(drx), .o_rx_valid(dval));
  pcf_chk pcf_chk_i (.i_clk(clk), .i_rst(rst),
    .tx_master_clock(pcf_link_if_i.tx_master_clock),
    .rx_master_clock_powerdown_pin(pcf_link_if_i.rx_master_clock_powerdown_pin),
    .rx_bit_clock_ratio_select_pin(pcf_link_if_i.rx_bit_clock_ratio_select_pin),
    .tx_frame_sync(pcf_link_if_i.tx_frame_sync), .rx_frame_sync(pcf_link_if_i.rx_frame_sync),
    .o_power(dpow), .o_frame_mode(dmode), .o_ratio(drat), .o_tx_taken(dtaken));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_dev(input logic [7:0] h, input logic [7:0] d,
    input logic lp);
    return lp ? d : h;
  endfunction : exp_dev
  task automatic chk(input logic ok, input string what);
    samples_checked++;
    if (!ok) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask : pause
  task automatic waitp(input pcf_power_t p, input int n);
    for (int i = 0; i < n && dpow !== p; i++) @(negedge clk);
  endtask : waitp
  // First frame after a word change may still carry the old word
  task automatic xfer(input logic [7:0] h, input logic [7:0] d);
    htx = h;
    dtx = d;
    pause(2 * FR);
    for (int i = 0; i < 2 * FR && dtaken !== 1'b1; i++) @(negedge clk);
    chk(dtaken === 1'b1, "word taken");
    for (int i = 0; i < 2 * FR && dval !== 1'b1; i++) @(negedge clk);
    chk(drx === exp_dev(h, d, loop), "codec word");
    for (int i = 0; i < 2 * FR && hval !== 1'b1; i++) @(negedge clk);
    chk(hrx === d, "host word");
  endtask : xfer
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      $display("[FAIL] %0t run too long", $time);
      conclude();
    end
  end
  initial begin
    {run, smode, slevel} = 3'h7;
    {pdn, mrun, notx, stop, loop} = 5'h00;
    fmode = PCF_FRAME_SHORT;
    {htx, dtx} = 16'h0;
    pause(16);
    rst = 1'b0;
    chk(dmode === PCF_FRAME_SHORT, "mode after reset");
    waitp(PCF_PWR_UP, 8 * FR);
    chk(dpow === PCF_PWR_UP, "power up");
    @(posedge pcf_link_if_i.tx_master_clock);
    @(negedge clk);
    t0 = cyc;
    @(posedge pcf_link_if_i.tx_master_clock);
    @(negedge clk);
    chk(cyc - t0 == MC, "master clock period");
    @(posedge pcf_link_if_i.tx_frame_sync);
    @(negedge clk);
    t0 = cyc;
    @(posedge pcf_link_if_i.tx_frame_sync);
    @(negedge clk);
    chk(cyc - t0 == FR, "frame period");
    xfer(8'h00, 8'hff);
    xfer(8'h81, 8'h7e);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      xfer(seed[7:0], seed[15:8]);
    end
    fmode = PCF_FRAME_LONG;
    xfer(8'h5a, 8'ha5);
    chk(dmode === PCF_FRAME_LONG, "long mode");
    seed = lfsr(seed);
    xfer(seed[7:0], seed[15:8]);
    fmode = PCF_FRAME_SHORT;
    xfer(8'h3c, 8'hc3);
    chk(dmode === PCF_FRAME_SHORT, "back to short");
    $display("test frames done");
    notx = 1'b1;
    fmode = PCF_FRAME_LONG;
    pause(3 * FR);
    chk(dmode === PCF_FRAME_SHORT, "long receive only");
    notx = 1'b0;
    fmode = PCF_FRAME_SHORT;
    loop = 1'b1;
    xfer(8'h00, 8'h96);
    loop = 1'b0;
    smode = 1'b0;
    xfer(8'h69, 8'h2d);
    chk(drat === PCF_RATIO_HI, "ratio held while clocking");
    smode = 1'b1;
    fmode = PCF_FRAME_LONG;
    slevel = 1'b0;
    pause(40 * MC);
    chk(drat === PCF_RATIO_LO, "strap low");
    slevel = 1'b1;
    pause(40 * MC);
    chk(drat === PCF_RATIO_HI, "strap high");
    chk(dmode === PCF_FRAME_LONG, "long before down");
    $display("test modes done");
    pdn = 1'b1;
    waitp(PCF_PWR_DOWN, 40 * MC);
    chk(dpow === PCF_PWR_DOWN, "pin high");
    pause(2);
    chk(dmode === PCF_FRAME_SHORT, "short while down");
    {pdn, mrun} = 2'b01;
    waitp(PCF_PWR_UP, 8 * FR);
    chk(dpow === PCF_PWR_UP, "pin clocking");
    {pdn, mrun, stop} = 3'h1;
    waitp(PCF_PWR_DOWN, 40 * FR);
    chk(dpow === PCF_PWR_DOWN, "frames lost");
    stop = 1'b0;
    waitp(PCF_PWR_UP, 8 * FR);
    chk(dpow === PCF_PWR_UP, "frames back");
    run = 1'b0;
    pause(40 * FR);
    chk(dpow === PCF_PWR_UP, "no master clock");
    run = 1'b1;
    xfer(8'hff, 8'h00);
    $display("test power done");
    conclude();
  end
endmodule : pcm_codec_clock_frame_control_tb_top
